// >>> include/osu_pkg.sv
package osu_pkg;

    // register placement
    localparam int unsigned APB_AW        = 12;
    localparam logic [31:0] REG_BASE      = 32'hffff83c0;
    localparam logic [31:0] ICS_PRINTED   = 32'hffff83c0;
    localparam logic [31:0] OCS_PRINTED   = 32'hffff83c2;
    localparam logic [9:0]  ICS_IDX       = 10'(ICS_PRINTED - REG_BASE);
    localparam logic [9:0]  OCS_IDX       = 10'(OCS_PRINTED - REG_BASE);

    // input control/status fields
    localparam int unsigned FLAG_LSB      = 12;
    localparam int unsigned IN_IRQEN_BIT  = 8;
    localparam int unsigned MODE_LSB      = 0;
    localparam logic [15:0] ICS_RESET     = 16'h0000;

    // output short control/status fields
    localparam int unsigned OSF_BIT       = 15;
    localparam int unsigned OCE_BIT       = 9;
    localparam int unsigned OIE_BIT       = 8;
    localparam logic [15:0] OCS_RESET     = 16'h0000;

    // timing
    localparam int unsigned DIV8          = 8;
    localparam int unsigned DIV16         = 16;
    localparam int unsigned DIV128        = 128;
    localparam logic [3:0]  SAMPLE_LAST   = 4'hf;
    localparam int unsigned NUM_REQ       = 4;
    localparam int unsigned NUM_PINS      = 6;
    localparam int unsigned NUM_PAIRS     = 3;

    typedef enum logic [1:0] {
        MODE_EDGE   = 2'b00,
        MODE_DIV8   = 2'b01,
        MODE_DIV16  = 2'b10,
        MODE_DIV128 = 2'b11
    } osu_mode_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } osu_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } osu_apb_rsp_t;

    typedef struct packed {
        logic ch3_out_b;
        logic ch3_out_d;
        logic ch4_out_a;
        logic ch4_out_b;
        logic ch4_out_c;
        logic ch4_out_d;
    } osu_pwm_pins_t;

endpackage : osu_pkg

// >>> src/osu_req_detect.sv
`timescale 1ns/1ps
module osu_req_detect (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              req_n,
    input  wire osu_pkg::osu_mode_t mode,
    input  wire logic              tick8,
    input  wire logic              tick16,
    input  wire logic              tick128,
    output logic                   accept
);
    import osu_pkg::*;

    typedef struct packed {
        logic       prev_level;
        logic [3:0] low_cnt;
        logic       accept;
    } osu_det_t;

    osu_det_t st_reg;
    osu_det_t st_next;
    logic     tick;

    always_comb begin
        st_next        = st_reg;
        st_next.accept = 1'b0;
        st_next.prev_level = req_n;
        unique case (mode)
            MODE_DIV8:   tick = tick8;
            MODE_DIV16:  tick = tick16;
            MODE_DIV128: tick = tick128;
            MODE_EDGE:   tick = 1'b0;
        endcase
        if (mode == MODE_EDGE) begin
            st_next.low_cnt = 4'h0;
            st_next.accept  = st_reg.prev_level & ~req_n;  // see [RULE1]
        end else if (tick) begin
            if (req_n) begin
                st_next.low_cnt = 4'h0;  // see [RULE13]
            end else if (st_reg.low_cnt == SAMPLE_LAST) begin
                st_next.low_cnt = 4'h0;
                st_next.accept  = 1'b1;  // see [RULE13]
            end else begin
                st_next.low_cnt = st_reg.low_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{prev_level: 1'b1, low_cnt: 4'h0, accept: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign accept = st_reg.accept;

endmodule : osu_req_detect

// >>> src/osu_top.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// What this block does
// [RULE1] two-bit mode per input: edge or sampling
// [RULE2] accepted request sets its sticky flag
// [RULE3] any input flag forces pins high-impedance
// [RULE4] flag clears on zero write after read
// [RULE5] input flag with enable raises interrupt
// [RULE6] pair low beyond one cycle forces hi-z
// [RULE7] three monitored pin pairs compared
// [RULE8] compare feature removable by variant parameter
// [RULE9] registers reset by power-on only
// [RULE10] input bits 11 to 9 read zero
// [RULE11] short flag only zero-write clears it
// [RULE12] oscillator stop or standby forces hi-z
// [RULE13] sixteen consecutive low samples, high rejects
// [RULE14] short flag, compare enable, interrupt enable
// [RULE15] compare hi-z needs both enables, plus interrupt
// [RULE16] hi-z holds until causing flags cleared
module osu_top #(
    parameter bit HAS_OUTPUT_COMPARE = 1'b1
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire osu_pkg::osu_apb_req_t apb_req,
    output osu_pkg::osu_apb_rsp_t      apb_rsp,
    input  wire logic [3:0]            shutdown_request_inputs_n,
    input  wire osu_pkg::osu_pwm_pins_t pwm_pins,
    input  wire logic                  osc_stop,
    input  wire logic                  standby,
    output logic [5:0]                 hiz_force,
    output logic                       input_irq,
    output logic                       output_irq
);
    import osu_pkg::*;

    typedef struct packed {
        logic [3:0]  req_flag;
        logic [3:0]  flag_seen;
        logic        input_irq_enable;
        logic [7:0]  modes;
        logic        output_short_flag;
        logic        osf_seen;
        logic        output_compare_enable;
        logic        output_short_irq_enable;
        logic [2:0]  pair_low;
        logic [6:0]  presc;
        logic [15:0] rdata;
        logic        slverr;
        logic        hiz;
        logic        in_irq;
        logic        out_irq;
    } osu_core_t;

    osu_core_t  st_reg;
    osu_core_t  st_next;
    logic [3:0] accept;
    logic       tick8;
    logic       tick16;
    logic       tick128;
    logic [2:0] pair_now;
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd;

    function automatic logic div_tick(input logic [6:0] cnt, input int unsigned div);
        logic [6:0] m;
        m = 7'(div - 1);
        return (cnt & m) == m;
    endfunction : div_tick

    // register select of an address, zero when unmapped or misaligned
    function automatic logic [1:0] reg_sel(input logic [APB_AW-1:0] addr);
        logic [9:0] idx;
        idx = addr[APB_AW-1:2];
        if (addr[1:0] != 2'b00) begin
            return 2'b00;
        end else if (idx == ICS_IDX) begin
            return 2'b01;
        end else if (idx == OCS_IDX) begin
            return 2'b10;
        end
        return 2'b00;
    endfunction : reg_sel

    function automatic logic [15:0] ics_word(input osu_core_t s);
        logic [15:0] w;
        w                          = 16'h0000;  // see [RULE10]
        w[FLAG_LSB +: NUM_REQ]     = s.req_flag;
        w[IN_IRQEN_BIT]            = s.input_irq_enable;
        w[MODE_LSB +: 8]           = s.modes;
        return w;
    endfunction : ics_word

    function automatic logic [15:0] ocs_word(input osu_core_t s);
        logic [15:0] w;
        w          = 16'h0000;
        w[OSF_BIT] = s.output_short_flag;  // see [RULE14]
        w[OCE_BIT] = s.output_compare_enable;
        w[OIE_BIT] = s.output_short_irq_enable;
        return w;
    endfunction : ocs_word

    assign tick8   = div_tick(st_reg.presc, DIV8);
    assign tick16  = div_tick(st_reg.presc, DIV16);
    assign tick128 = div_tick(st_reg.presc, DIV128);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REQ; gi++) begin : g_det
            osu_req_detect u_det (
                .ref_clk (ref_clk),
                .nrst    (nrst),
                .req_n   (shutdown_request_inputs_n[gi]),
                .mode    (osu_mode_t'(st_reg.modes[2*gi +: 2])),
                .tick8   (tick8),
                .tick16  (tick16),
                .tick128 (tick128),
                .accept  (accept[gi])
            );
        end
    endgenerate

    // both pins of a pair driven low this cycle
    assign pair_now[0] = ~pwm_pins.ch3_out_b & ~pwm_pins.ch3_out_d;  // see [RULE7]
    assign pair_now[1] = ~pwm_pins.ch4_out_a & ~pwm_pins.ch4_out_c;  // see [RULE7]
    assign pair_now[2] = ~pwm_pins.ch4_out_b & ~pwm_pins.ch4_out_d;  // see [RULE7]

    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign wr     = access & apb_req.pwrite & ~st_reg.slverr;
    assign rd     = access & ~apb_req.pwrite & ~st_reg.slverr;

    always_comb begin
        logic [1:0]  sel;
        logic [3:0]  clr;
        logic        osf_clr;
        logic        short_now;
        sel       = reg_sel(apb_req.paddr);
        clr       = 4'h0;
        osf_clr   = 1'b0;
        short_now = 1'b0;
        st_next   = st_reg;

        st_next.presc = st_reg.presc + 7'h01;

        // setup phase latches the read word so prdata comes from a flop
        if (setup) begin
            st_next.slverr = (sel == 2'b00);
            unique case (sel)
                2'b01:   st_next.rdata = ics_word(st_reg);
                2'b10:   st_next.rdata = ocs_word(st_reg);
                default: st_next.rdata = 16'h0000;
            endcase
        end

        // remember which flags software has seen as one
        if (rd && reg_sel(apb_req.paddr) == 2'b01) begin
            st_next.flag_seen = st_reg.rdata[FLAG_LSB +: NUM_REQ];  // see [RULE4]
        end
        if (rd && reg_sel(apb_req.paddr) == 2'b10) begin
            st_next.osf_seen = st_reg.rdata[OSF_BIT];  // see [RULE11]
        end

        if (wr && sel == 2'b01) begin
            if (apb_req.pstrb[1]) begin
                // ones written to flags do nothing
                clr = ~apb_req.pwdata[FLAG_LSB +: NUM_REQ] & st_reg.flag_seen;  // see [RULE4]
                st_next.flag_seen        = 4'h0;
                st_next.input_irq_enable = apb_req.pwdata[IN_IRQEN_BIT];
            end
            if (apb_req.pstrb[0]) begin
                st_next.modes = apb_req.pwdata[MODE_LSB +: 8];  // see [RULE1]
            end
        end
        if (wr && sel == 2'b10 && apb_req.pstrb[1]) begin
            osf_clr = ~apb_req.pwdata[OSF_BIT] & st_reg.osf_seen;  // see [RULE11]
            st_next.osf_seen                = 1'b0;
            st_next.output_compare_enable   = apb_req.pwdata[OCE_BIT];
            st_next.output_short_irq_enable = apb_req.pwdata[OIE_BIT];
        end

        // a new request in the clearing cycle keeps its flag
        st_next.req_flag = (st_reg.req_flag & ~clr) | accept;  // see [RULE2]

        // low for two consecutive cycles is longer than one cycle
        st_next.pair_low = pair_now;
        if (HAS_OUTPUT_COMPARE) begin  // see [RULE8]
            short_now = st_reg.output_compare_enable
                      & |(pair_now & st_reg.pair_low);  // see [RULE6]
        end
        st_next.output_short_flag = (st_reg.output_short_flag & ~osf_clr)
                                  | short_now;  // see [RULE14]

        st_next.hiz = |st_next.req_flag  // see [RULE3]
                    | (st_next.output_short_flag & st_next.output_compare_enable
                       & st_next.output_short_irq_enable)  // see [RULE15]
                    | osc_stop | standby;  // see [RULE12]
        st_next.in_irq  = |st_next.req_flag & st_next.input_irq_enable;  // see [RULE5]
        st_next.out_irq = st_next.output_short_flag & st_next.output_compare_enable
                        & st_next.output_short_irq_enable;  // see [RULE15]
    end

    // nrst is the power-on reset; nothing else clears the registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;  // see [RULE9]
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp.prdata  = {16'h0000, st_reg.rdata};
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access & st_reg.slverr;
    assign hiz_force       = {NUM_PINS{st_reg.hiz}};  // see [RULE16]
    assign input_irq       = st_reg.in_irq;
    assign output_irq      = st_reg.out_irq;

endmodule : osu_top

// >>> testbench/osu_fault_src.sv
`timescale 1ns/1ps
module osu_fault_src (
    input wire logic  ref_clk,
    input wire logic [3:0] fault,
    output logic [3:0]     req_n
);
    // pulled-up request lines, pulled low while a fault is reported
    initial req_n = 4'hf;
    always @(posedge ref_clk) begin
        req_n <= ~fault;
    end
endmodule : osu_fault_src

// >>> testbench/osu_top_asserts.sv
`timescale 1ns/1ps
module osu_top_asserts
    import osu_pkg::*;
#(
    parameter bit HAS_OUTPUT_COMPARE = 1'b1
) (
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire osu_pkg::osu_apb_req_t apb_req,
    input wire osu_pkg::osu_apb_rsp_t apb_rsp,
    input wire logic                  osc_stop,
    input wire logic                  standby,
    input wire logic [5:0]            hiz_force,
    input wire logic                  input_irq,
    input wire logic                  output_irq
);
    logic wr;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_hiz_uniform: assert property (hiz_force == 6'h00 || hiz_force == 6'h3f)
        else $error("hiz bits differ");
    a_stop_hiz: assert property ((osc_stop || standby) |=> hiz_force == 6'h3f)
        else $error("no hiz on stop or standby");
    a_inirq_hiz: assert property (input_irq |-> hiz_force == 6'h3f)
        else $error("input irq without hiz");
    a_outirq_hiz: assert property (output_irq |-> hiz_force == 6'h3f)
        else $error("output irq without hiz");
    a_inirq_hold: assert property ($fell(input_irq) |-> $past(wr))
        else $error("input irq dropped without write");
    a_outirq_hold: assert property ($fell(output_irq) |-> $past(wr))
        else $error("output irq dropped without write");
    a_hiz_release: assert property ($fell(hiz_force[0]) |-> !input_irq && !output_irq)
        else $error("hiz released with irq pending");
    a_no_compare: assert property (!HAS_OUTPUT_COMPARE |-> !output_irq)
        else $error("compare irq in variant without compare");
    a_misalign_err: assert property (apb_req.psel && apb_req.penable && apb_req.paddr[1:0] != 2'b00
        |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("misaligned access not refused");
endmodule : osu_top_asserts

bind osu_top osu_top_asserts #(.HAS_OUTPUT_COMPARE(HAS_OUTPUT_COMPARE)) u_osu_top_asserts (
    .ref_clk, .nrst, .apb_req, .apb_rsp, .osc_stop, .standby, .hiz_force, .input_irq, .output_irq
);

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import osu_pkg::*;
    localparam logic [11:0] A_ICS = 12'(4 * ICS_IDX);
    localparam logic [11:0] A_OCS = 12'(4 * OCS_IDX);
    logic          ref_clk;
    logic          nrst;
    osu_apb_req_t  req;
    osu_apb_rsp_t  rsp;
    logic [3:0]    flt;
    logic [3:0]    req_n;
    osu_pwm_pins_t pwm;
    logic          osc;
    logic          stby;
    logic [5:0]    hiz;
    logic [5:0]    hiz2;
    logic          iirq;
    logic          oirq;
    logic [31:0]   rd;
    logic          perr;
    int            mismatches;
    int            n_compared;
    int            dv;
    logic [5:0]    pm [5] = '{6'h30, 6'h28, 6'h0a, 6'h05, 6'h30};
    int            pl [5] = '{1, 3, 3, 3, 3};
    bit            pe [5] = '{0, 0, 1, 1, 1};

    osu_fault_src u_osu_fault_src (.ref_clk, .fault(flt), .req_n);
    osu_top u_osu_top (.ref_clk, .nrst, .apb_req(req), .apb_rsp(rsp),
        .shutdown_request_inputs_n(req_n), .pwm_pins(pwm), .osc_stop(osc), .standby(stby),
        .hiz_force(hiz), .input_irq(iirq), .output_irq(oirq));
    osu_top #(.HAS_OUTPUT_COMPARE(1'b0)) u_osu_top_nocmp (.ref_clk, .nrst, .apb_req(req),
        .apb_rsp(), .shutdown_request_inputs_n(req_n), .pwm_pins(pwm), .osc_stop(osc),
        .standby(stby), .hiz_force(hiz2), .input_irq(), .output_irq());

    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d, 4'h3};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (rsp.pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd   = rsp.prdata;
        perr = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        req = '0;
        flt = 4'h0;
        pwm = 6'h3f;
        osc = 1'b0;
        stby = 1'b0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(A_ICS, 32'h0);
        rchk(A_OCS, 32'h0);
        chk(32'(perr), 32'h0);
        rchk(12'h004, 32'h0);
        chk(32'(perr), 32'h1);
        rchk(12'h002, 32'h0);
        chk(32'(perr), 32'h1);
        apb(1'b1, A_ICS, 32'hffe4);
        rchk(A_ICS, 32'h01e4);
        flt[0] <= 1'b1;
        cyc(6);
        rchk(A_ICS, 32'h11e4);
        chk(32'(hiz), 32'h3f);
        chk(32'(iirq), 32'h1);
        apb(1'b1, A_ICS, 32'hf1e4);
        apb(1'b1, A_ICS, 32'h01e4);
        rchk(A_ICS, 32'h11e4);
        flt[0] <= 1'b0;
        apb(1'b1, A_ICS, 32'h00e4);
        rchk(A_ICS, 32'h00e4);
        chk(32'(hiz), 32'h0);
        chk(32'(iirq), 32'h0);
        // break of two high samples restarts the sixteen-sample count
        for (int i = 1; i < 4; i++) begin
            dv = (i == 1) ? 8 : (i == 2) ? 16 : 128;
            flt[i] <= 1'b1;
            cyc(8 * dv);
            flt[i] <= 1'b0;
            cyc(2 * dv);
            flt[i] <= 1'b1;
            cyc(15 * dv - 3);
            chk(32'(hiz), 32'h0);
            cyc(dv + 12);
            chk(32'(hiz), 32'h3f);
            chk(32'(iirq), 32'h0);
            flt[i] <= 1'b0;
            rchk(A_ICS, 32'h00e4 | (32'h1000 << i));
            apb(1'b1, A_ICS, 32'h00e4);
        end
        apb(1'b1, A_OCS, 32'h0200);
        pwm <= 6'h0f;
        cyc(3);
        pwm <= 6'h3f;
        rchk(A_OCS, 32'h8200);
        chk(32'(hiz), 32'h0);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, A_OCS, 32'h0300);
            pwm <= ~pm[k];
            cyc(pl[k]);
            pwm <= 6'h3f;
            cyc(2);
            chk(32'(hiz), pe[k] ? 32'h3f : 32'h0);
            chk(32'(oirq), 32'(pe[k]));
            chk(32'(hiz2), 32'h0);
            rchk(A_OCS, pe[k] ? 32'h8300 : 32'h0300);
        end
        // a one written to the short flag leaves it set
        apb(1'b1, A_OCS, 32'h8300);
        rchk(A_OCS, 32'h8300);
        apb(1'b1, A_OCS, 32'h0000);
        osc <= 1'b1;
        cyc(2);
        chk(32'(hiz), 32'h3f);
        osc <= 1'b0;
        stby <= 1'b1;
        cyc(2);
        chk(32'(hiz2), 32'h3f);
        stby <= 1'b0;
        cyc(3);
        chk(32'(hiz), 32'h0);
        rchk(A_ICS, 32'h00e4);
        tally_and_finish();
    end
endmodule : tb_top
